// file: ccr_pkg.sv
`default_nettype none
package ccr_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MV_W   = 13;
  localparam int HMA_W  = 11;

  // Register offsets
  localparam logic [7:0] CHARGER_CONTROL_ADDR      = 8'h06;
  localparam logic [7:0] CHARGE_VOLTAGE_ADDR       = 8'h07;
  localparam logic [7:0] CHARGE_CURRENT_ADDR       = 8'h08;
  localparam logic [7:0] CHARGE_TERMINATION_ADDR   = 8'h09;
  localparam logic [7:0] CHARGER_STATUS_ADDR       = 8'h0C;

  // Writable bit masks; everything else reads zero
  localparam logic [7:0] CHARGER_CONTROL_MASK      = 8'h37;
  localparam logic [7:0] CHARGE_VOLTAGE_MASK       = 8'h3F;
  localparam logic [7:0] CHARGE_CURRENT_MASK       = 8'h0F;
  localparam logic [7:0] CHARGE_TERMINATION_MASK   = 8'h07;

  // Reset values
  localparam logic [7:0] CHARGER_CONTROL_RST       = 8'h00;
  localparam logic [7:0] CHARGE_VOLTAGE_RST        = 8'h00;
  localparam logic [7:0] CHARGE_CURRENT_RST        = 8'h00;
  localparam logic [7:0] CHARGE_TERMINATION_RST    = 8'h00;

  // Field positions
  localparam int EN_SEL_MSB = 5;
  localparam int EN_SEL_LSB = 4;
  localparam int PQ_MSB     = 2;
  localparam int CV_MSB     = 5;
  localparam int CC_MSB     = 3;
  localparam int TRM_MSB    = 2;

  // Charger enable selection codes
  typedef enum logic [1:0] {
    CCR_EN_OFF     = 2'b00,
    CCR_EN_ON      = 2'b01,
    CCR_EN_PIN     = 2'b10,
    CCR_EN_ON_ALT  = 2'b11
  } ccr_en_sel_type;

  // Voltage settings in millivolts
  localparam logic [12:0] PQ_BASE_MV   = 13'h0960;
  localparam logic [12:0] PQ_STEP_MV   = 13'h0064;
  localparam logic [12:0] CV_BASE_MV   = 13'h0D34;
  localparam logic [12:0] CV_COARSE_MV = 13'h0050;
  localparam logic [12:0] CV_FINE_MV   = 13'h0014;
  localparam logic [12:0] CV_MIN_MV    = 13'h0DAC;
  localparam logic [12:0] CV_MAX_MV    = 13'h1130;

  // Currents in half-milliamp units for the 50 mOhm sense resistor
  localparam logic [10:0] FC_COARSE_HMA = 11'h0190;
  localparam logic [10:0] FC_FINE_HMA   = 11'h0064;
  localparam logic [10:0] FC_MIN_HMA    = 11'h00C8;
  localparam logic [10:0] FC_MAX_HMA    = 11'h05DC;
  localparam logic [10:0] TRM_HMA_0     = 11'h0032;
  localparam logic [10:0] TRM_HMA_1     = 11'h0064;
  localparam logic [10:0] TRM_HMA_2     = 11'h0096;
  localparam logic [10:0] TRM_HMA_3     = 11'h00C8;
  localparam logic [10:0] TRM_HMA_4     = 11'h012C;
  localparam logic [10:0] TRM_HMA_5     = 11'h0190;
  localparam logic [10:0] TRM_HMA_6     = 11'h01F4;
  localparam logic [10:0] TRM_HMA_7     = 11'h0258;
endpackage
`default_nettype wire

// file: ccr_decode.sv
`timescale 1ns/100ps
`default_nettype none
module ccr_decode (
  input  wire logic [2:0]  precharge_threshold_code,
  input  wire logic [5:0]  charge_voltage_code,
  input  wire logic [3:0]  charge_current_code,
  input  wire logic [2:0]  termination_current_code,
  input  wire logic        sense_high,
  output logic      [12:0] precharge_mv,
  output logic      [12:0] charge_mv,
  output logic      [10:0] fast_hma,
  output logic      [10:0] term_hma
);
  // Halve a current when the larger sense resistor is fitted
  function automatic logic [10:0] scale_sense(input logic [10:0] hma, input logic high);
    scale_sense = high ? (hma >> 1) : hma;
  endfunction

  // Coarse plus fine voltage steps, held inside the legal window
  function automatic logic [12:0] cv_mv(input logic [5:0] code);
    logic [12:0] raw;
    raw = ccr_pkg::CV_BASE_MV + 13'(code[5:2]) * ccr_pkg::CV_COARSE_MV
          + 13'(code[1:0]) * ccr_pkg::CV_FINE_MV;
    if (raw < ccr_pkg::CV_MIN_MV) begin
      cv_mv = ccr_pkg::CV_MIN_MV;
    end else if (raw > ccr_pkg::CV_MAX_MV) begin
      cv_mv = ccr_pkg::CV_MAX_MV;
    end else begin
      cv_mv = raw;
    end
  endfunction

  // Current step table, floored at the lowest usable limit
  function automatic logic [10:0] fc_hma(input logic [3:0] code);
    logic [10:0] raw;
    raw = 11'(code[3:2]) * ccr_pkg::FC_COARSE_HMA + 11'(code[1:0]) * ccr_pkg::FC_FINE_HMA;
    fc_hma = (raw < ccr_pkg::FC_MIN_HMA) ? ccr_pkg::FC_MIN_HMA : raw;
  endfunction

  // Termination steps are irregular above code 3, so a table is clearer
  function automatic logic [10:0] trm_hma(input logic [2:0] code);
    case (code)
      3'h0:    trm_hma = ccr_pkg::TRM_HMA_0;
      3'h1:    trm_hma = ccr_pkg::TRM_HMA_1;
      3'h2:    trm_hma = ccr_pkg::TRM_HMA_2;
      3'h3:    trm_hma = ccr_pkg::TRM_HMA_3;
      3'h4:    trm_hma = ccr_pkg::TRM_HMA_4;
      3'h5:    trm_hma = ccr_pkg::TRM_HMA_5;
      3'h6:    trm_hma = ccr_pkg::TRM_HMA_6;
      default: trm_hma = ccr_pkg::TRM_HMA_7;
    endcase
  endfunction

  // Pure decode; the top registers every result
  always_comb begin
    precharge_mv = ccr_pkg::PQ_BASE_MV + 13'(precharge_threshold_code) * ccr_pkg::PQ_STEP_MV;
    charge_mv    = cv_mv(charge_voltage_code);
    fast_hma     = scale_sense(fc_hma(charge_current_code), sense_high);
    term_hma     = scale_sense(trm_hma(termination_current_code), sense_high);
  end
endmodule
`default_nettype wire

// file: ccr_config_regs.sv
// Operation
// - Enable select: 00 off, 01/11 on, 10 pin
// - Precharge threshold 2.4V plus 0.1V per code
// - Voltage: 80mV coarse, 20mV fine, 3.5V to 4.40V
// - Fast current 200mA/50mA steps, halved with 100mOhm
// - Termination 25 to 300mA table, halved with 100mOhm
// - Control: enable select 5:4, threshold 2:0
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ccr_config_regs (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [7:0]  RD_DATA,
  input  wire logic        MULTIPURPOSE_INPUT_ZERO,
  input  wire logic        SENSE_100_MOHM,
  output logic             CHARGER_ENABLE,
  output logic      [12:0] PRECHARGE_MV,
  output logic      [12:0] CHARGE_MV,
  output logic      [10:0] FAST_CURRENT_HMA,
  output logic      [10:0] TERM_CURRENT_HMA
);
  logic [7:0]  charger_control;
  logic [7:0]  charge_voltage_setting;
  logic [7:0]  charge_current_limit;
  logic [7:0]  charge_termination_control;
  logic        mpc_meta;
  logic        mpc_sync;
  logic        sense_meta;
  logic        sense_sync;
  logic        next_enable;
  logic [7:0]  next_rd_data;
  logic [12:0] next_precharge_mv;
  logic [12:0] next_charge_mv;
  logic [10:0] next_fast_hma;
  logic [10:0] next_term_hma;
  ccr_pkg::ccr_en_sel_type charger_enable_select;

  assign charger_enable_select =
    ccr_pkg::ccr_en_sel_type'(charger_control[ccr_pkg::EN_SEL_MSB:ccr_pkg::EN_SEL_LSB]);

  // Pins cross in from outside the clock domain through two flops
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mpc_meta   <= 1'b0;
      mpc_sync   <= 1'b0;
      sense_meta <= 1'b0;
      sense_sync <= 1'b0;
    end else begin
      mpc_meta   <= MULTIPURPOSE_INPUT_ZERO;
      mpc_sync   <= mpc_meta;
      sense_meta <= SENSE_100_MOHM;
      sense_sync <= sense_meta;
    end
  end

  // Register writes; masks drop unused bits so read-modify-write is safe
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      charger_control            <= ccr_pkg::CHARGER_CONTROL_RST;
      charge_voltage_setting     <= ccr_pkg::CHARGE_VOLTAGE_RST;
      charge_current_limit       <= ccr_pkg::CHARGE_CURRENT_RST;
      charge_termination_control <= ccr_pkg::CHARGE_TERMINATION_RST;
    end else if (WR_EN) begin
      case (ADDR)
        ccr_pkg::CHARGER_CONTROL_ADDR: begin
          charger_control <= WR_DATA & ccr_pkg::CHARGER_CONTROL_MASK;
        end
        ccr_pkg::CHARGE_VOLTAGE_ADDR: begin
          charge_voltage_setting <= WR_DATA & ccr_pkg::CHARGE_VOLTAGE_MASK;
        end
        ccr_pkg::CHARGE_CURRENT_ADDR: begin
          charge_current_limit <= WR_DATA & ccr_pkg::CHARGE_CURRENT_MASK;
        end
        ccr_pkg::CHARGE_TERMINATION_ADDR: begin
          charge_termination_control <= WR_DATA & ccr_pkg::CHARGE_TERMINATION_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets and idle cycles return zero
  always_comb begin
    next_rd_data = 8'h00;
    if (RD_EN) begin
      case (ADDR)
        ccr_pkg::CHARGER_CONTROL_ADDR:    next_rd_data = charger_control;
        ccr_pkg::CHARGE_VOLTAGE_ADDR:     next_rd_data = charge_voltage_setting;
        ccr_pkg::CHARGE_CURRENT_ADDR:     next_rd_data = charge_current_limit;
        ccr_pkg::CHARGE_TERMINATION_ADDR: next_rd_data = charge_termination_control;
        ccr_pkg::CHARGER_STATUS_ADDR:     next_rd_data = {6'h00, mpc_sync, CHARGER_ENABLE};
        default:                          next_rd_data = 8'h00;
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= next_rd_data;
    end
  end

  // Effective enable combines selection with the synchronised pin
  always_comb begin
    case (charger_enable_select)
      ccr_pkg::CCR_EN_OFF:    next_enable = 1'b0;
      ccr_pkg::CCR_EN_ON:     next_enable = 1'b1;
      ccr_pkg::CCR_EN_PIN:    next_enable = mpc_sync;
      ccr_pkg::CCR_EN_ON_ALT: next_enable = 1'b1;
      default:                next_enable = 1'b0;
    endcase
  end

  // Analog settings are decoded from the current register contents
  ccr_decode u_decode (
    .precharge_threshold_code (charger_control[ccr_pkg::PQ_MSB:0]),
    .charge_voltage_code      (charge_voltage_setting[ccr_pkg::CV_MSB:0]),
    .charge_current_code      (charge_current_limit[ccr_pkg::CC_MSB:0]),
    .termination_current_code (charge_termination_control[ccr_pkg::TRM_MSB:0]),
    .sense_high               (sense_sync),
    .precharge_mv             (next_precharge_mv),
    .charge_mv                (next_charge_mv),
    .fast_hma                 (next_fast_hma),
    .term_hma                 (next_term_hma)
  );

  // Registered outputs keep glitches off the analog trim lines
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      CHARGER_ENABLE <= 1'b0;
    end else begin
      CHARGER_ENABLE <= next_enable;
    end
  end

  // Settings follow the decoder one clock later
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      PRECHARGE_MV     <= ccr_pkg::PQ_BASE_MV;
      CHARGE_MV        <= ccr_pkg::CV_MIN_MV;
      FAST_CURRENT_HMA <= ccr_pkg::FC_MIN_HMA;
      TERM_CURRENT_HMA <= ccr_pkg::TRM_HMA_0;
    end else begin
      PRECHARGE_MV     <= next_precharge_mv;
      CHARGE_MV        <= next_charge_mv;
      FAST_CURRENT_HMA <= next_fast_hma;
      TERM_CURRENT_HMA <= next_term_hma;
    end
  end

  // Enable tracks the selection and the pin seen one cycle before
  enable_decode_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !$past(SYS_RST) |-> CHARGER_ENABLE ==
      (($past(charger_control[5:4]) == 2'b00) ? 1'b0 :
       ($past(charger_control[5:4]) == 2'b10) ? $past(mpc_sync) : 1'b1))
    else $error("charger enable does not follow selection");

  // Pin mode: a pin rise reaches the enable three cycles later
  pin_gating_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (charger_control[5:4] == 2'b10 && MULTIPURPOSE_INPUT_ZERO) ##1
    (charger_control[5:4] == 2'b10 && MULTIPURPOSE_INPUT_ZERO) [*2]
    |=> CHARGER_ENABLE)
    else $error("pin-gated enable did not rise");

  // Threshold is linear from the base in fixed steps
  precharge_map_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    !$past(SYS_RST) |-> PRECHARGE_MV ==
      13'(13'h0960 + 13'h0064 * 13'($past(charger_control[2:0]))))
    else $error("precharge threshold mapping wrong");

  // Coarse code zero always gives the floor voltage
  voltage_floor_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (charge_voltage_setting[5:2] == 4'h0) |=> CHARGE_MV == 13'h0DAC)
    else $error("charge voltage floor wrong");

  // Mid-range code gives exact coarse plus fine value, 4.28 V
  voltage_step_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (charge_voltage_setting[5:0] == 6'h2D) |=> CHARGE_MV == 13'h10B8)
    else $error("charge voltage step wrong");

  // Every code past the top coarse step clamps to the ceiling
  voltage_clamp_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (charge_voltage_setting[5:2] > 4'hC) |=> CHARGE_MV == 13'h1130)
    else $error("charge voltage clamp wrong");

  // Full-scale current code gives 750 mA, halved with the larger resistor
  current_scale_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (charge_current_limit[3:0] == 4'hF) |=>
      FAST_CURRENT_HMA == ($past(sense_sync) ? 11'h02EE : 11'h05DC))
    else $error("fast charge current scale wrong");

  // Smallest termination code gives 25 mA or 12.5 mA
  term_floor_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (charge_termination_control[2:0] == 3'h0) |=>
      TERM_CURRENT_HMA == ($past(sense_sync) ? 11'h0019 : 11'h0032))
    else $error("termination current mapping wrong");

  // A control write lands in the documented field positions
  ctrl_layout_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (WR_EN && ADDR == ccr_pkg::CHARGER_CONTROL_ADDR) |=>
      charger_control[5:4] == $past(WR_DATA[5:4]) &&
      charger_control[2:0] == $past(WR_DATA[2:0]))
    else $error("control field layout wrong");

  // Unused bits read back as zero whatever was written
  unused_zero_a: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (RD_EN && ADDR == ccr_pkg::CHARGER_CONTROL_ADDR) |=> (RD_DATA & 8'hC8) == 8'h00)
    else $error("unused control bits not zero");
endmodule
`default_nettype wire

// file: ccr_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ccr_config_regs_tb;
  logic        MCLK;
  logic        SYS_RST;
  logic [7:0]  ADDR;
  logic [7:0]  WR_DATA;
  logic        WR_EN;
  logic        RD_EN;
  logic [7:0]  RD_DATA;
  logic        MULTIPURPOSE_INPUT_ZERO;
  logic        SENSE_100_MOHM;
  logic        CHARGER_ENABLE;
  logic [12:0] PRECHARGE_MV;
  logic [12:0] CHARGE_MV;
  logic [10:0] FAST_CURRENT_HMA;
  logic [10:0] TERM_CURRENT_HMA;
  int          error_cnt;
  int          num_checks;
  logic [7:0]  rdat;

  ccr_config_regs dut_u (
    .MCLK                    (MCLK),
    .SYS_RST                 (SYS_RST),
    .ADDR                    (ADDR),
    .WR_DATA                 (WR_DATA),
    .WR_EN                   (WR_EN),
    .RD_EN                   (RD_EN),
    .RD_DATA                 (RD_DATA),
    .MULTIPURPOSE_INPUT_ZERO (MULTIPURPOSE_INPUT_ZERO),
    .SENSE_100_MOHM          (SENSE_100_MOHM),
    .CHARGER_ENABLE          (CHARGER_ENABLE),
    .PRECHARGE_MV            (PRECHARGE_MV),
    .CHARGE_MV               (CHARGE_MV),
    .FAST_CURRENT_HMA        (FAST_CURRENT_HMA),
    .TERM_CURRENT_HMA        (TERM_CURRENT_HMA)
  );

  // 100 ns clock
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  // Case equality so an unknown never passes for a match
  task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Land just past an edge so all its updates are settled
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR    <= a;
    WR_DATA <= d;
    WR_EN   <= 1'b1;
    @(posedge MCLK);
    WR_EN   <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    RD_EN <= 1'b1;
    @(posedge MCLK);
    RD_EN <= 1'b0;
    #1;
    d = RD_DATA;
  endtask

  task automatic results;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Registers clear to zero and outputs show the zero-code settings
  task automatic test_reset;
    for (int i = 0; i < 4; i++) begin
      rd(8'h06 + 8'(i), rdat);
      check("reset reg", 13'(rdat), 13'h0000);
    end
    check("reset enable", 13'(CHARGER_ENABLE), 13'h0000);
    check("reset precharge", PRECHARGE_MV, 13'h0960);
    check("reset voltage", CHARGE_MV, 13'h0DAC);
    check("reset fast", 13'(FAST_CURRENT_HMA), 13'h00C8);
    check("reset term", 13'(TERM_CURRENT_HMA), 13'h0032);
  endtask

  // Every select code against both pin levels; threshold field rides along
  task automatic test_enable;
    logic exp;
    for (int p = 0; p < 2; p++) begin
      MULTIPURPOSE_INPUT_ZERO <= p[0];
      wait_cyc(4); // Two sync stages plus output register
      for (int s = 0; s < 4; s++) begin
        wr(8'h06, {2'b11, s[1:0], 1'b1, 3'b101});
        wait_cyc(1);
        exp = (s == 1) || (s == 3) || (s == 2 && p == 1);
        check("enable", 13'(CHARGER_ENABLE), 13'(exp));
        check("precharge field", PRECHARGE_MV, 13'h0B54);
        rd(8'h06, rdat);
        check("control readback", 13'(rdat), 13'({2'b00, s[1:0], 4'h5}));
        rd(8'h0C, rdat);
        check("status", 13'(rdat), 13'({p[0], exp}));
      end
    end
  endtask

  task automatic test_precharge;
    for (int c = 0; c < 8; c++) begin
      wr(8'h06, 8'(c));
      wait_cyc(1);
      check("precharge", PRECHARGE_MV, 13'(2400 + 100 * c));
    end
  endtask

  // Full code space, covering the low and high clamps
  task automatic test_voltage;
    int v;
    for (int c = 0; c < 64; c++) begin
      wr(8'h07, 8'(c));
      wait_cyc(1);
      v = 3380 + 80 * (c >> 2) + 20 * (c & 3);
      v = (v < 3500) ? 3500 : ((v > 4400) ? 4400 : v);
      check("voltage", CHARGE_MV, 13'(v));
    end
  endtask

  // Currents for both sense resistors; code 15 is the largest allowed limit
  task automatic test_currents;
    int m;
    int tt[8] = '{25, 50, 75, 100, 150, 200, 250, 300};
    for (int r = 0; r < 2; r++) begin
      SENSE_100_MOHM <= r[0];
      wait_cyc(4);
      for (int c = 0; c < 16; c++) begin
        wr(8'h08, 8'(c));
        wait_cyc(1);
        m = 200 * (c >> 2) + 50 * (c & 3);
        m = (m < 100) ? 100 : m;
        check("fast", 13'(FAST_CURRENT_HMA), 13'(r ? m : 2 * m));
      end
      for (int c = 0; c < 8; c++) begin
        wr(8'h09, 8'(c));
        wait_cyc(1);
        check("term", 13'(TERM_CURRENT_HMA), 13'(r ? tt[c] : 2 * tt[c]));
      end
    end
  endtask

  // Unused bits, unmapped place, and a write followed at once by a read
  task automatic test_unused;
    logic [7:0] msk[4] = '{8'h37, 8'h3F, 8'h0F, 8'h07};
    for (int i = 0; i < 4; i++) begin
      wr(8'h06 + 8'(i), 8'hFF);
      rd(8'h06 + 8'(i), rdat);
      check("ones readback", 13'(rdat), 13'(msk[i]));
    end
    wr(8'h10, 8'hFF);
    rd(8'h10, rdat);
    check("unmapped", 13'(rdat), 13'h0000);
    @(posedge MCLK);
    ADDR    <= 8'h07;
    WR_DATA <= 8'hC9;
    WR_EN   <= 1'b1;
    @(posedge MCLK);
    WR_EN   <= 1'b0;
    RD_EN   <= 1'b1;
    @(posedge MCLK);
    RD_EN   <= 1'b0;
    #1;
    check("back to back", 13'(RD_DATA), 13'h0009);
    wait_cyc(1);
    check("read data drop", 13'(RD_DATA), 13'h0000);
  endtask

  // Main sequence; reset held three cycles
  initial begin
    error_cnt               = 0;
    num_checks              = 0;
    SYS_RST                 = 1'b1;
    ADDR                    = 8'h00;
    WR_DATA                 = 8'h00;
    WR_EN                   = 1'b0;
    RD_EN                   = 1'b0;
    MULTIPURPOSE_INPUT_ZERO = 1'b0;
    SENSE_100_MOHM          = 1'b0;
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    wait_cyc(2);
    test_reset();
    test_enable();
    test_precharge();
    test_voltage();
    test_currents();
    test_unused();
    results();
  end

  // Whole run needs well under 1500 cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
